// *** lcs_cell_asserts.sv ***
/*
 * Checker for the logic cell: function, enable and storage latency
 * relations seen at the top ports.
 * Assumes a bind from the bench top and a single clock domain.
 */
`timescale 1ns/100ps
module lcs_cell_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration
  input wire logic cell_enable,
  input wire logic [lcs_pkg::GSEL_W-1:0] gate1_select,
  input wire logic [lcs_pkg::GSEL_W-1:0] gate2_select,
  input wire logic [lcs_pkg::GSEL_W-1:0] gate3_select,
  input wire logic [lcs_pkg::GSEL_W-1:0] gate4_select,
  input wire logic [lcs_pkg::LINES-1:0] gate_polarity,
  input wire logic [2:0] function_mode,
  input wire logic output_polarity,
  input wire logic pin_output_enable,
  // results
  input wire logic cell_output,
  input wire logic cell_pin_out,
  input wire logic cell_pin_oe,
  input wire logic [lcs_pkg::LINES-1:0] gate_lines
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_pin_follow: assert property (
    cell_pin_out == cell_output) else $error("pin output differs from cell output");
  a_oe_gating: assert property (
    cell_pin_oe == (cell_enable && pin_output_enable)) else $error("pin enable wrong");
  a_disabled_low: assert property (
    !cell_enable |-> !cell_output && !cell_pin_oe) else $error("disabled cell drives");
  a_and4_comb: assert property (
    cell_enable && function_mode == lcs_pkg::FN_AND4 |-> cell_output == (&gate_lines ^ output_polarity))
    else $error("and4 result wrong");
  a_and_or: assert property (
    cell_enable && function_mode == lcs_pkg::FN_AND_OR |-> cell_output ==
    (((gate_lines[0] & gate_lines[1]) | (gate_lines[2] & gate_lines[3])) ^ output_polarity))
    else $error("and-or result wrong");
  a_or_xor: assert property (
    cell_enable && function_mode == lcs_pkg::FN_OR_XOR |-> cell_output ==
    (((gate_lines[0] | gate_lines[1]) ^ (gate_lines[2] | gate_lines[3])) ^ output_polarity))
    else $error("or-xor result wrong");
  // no chosen terms leaves each line at its polarity bit
  a_lines_fixed: assert property (
    gate1_select == 8'h00 && gate2_select == 8'h00 && gate3_select == 8'h00 && gate4_select == 8'h00
    |-> gate_lines == gate_polarity) else $error("gate line not at polarity");
  // two sync stages plus the state register
  a_dff_capture: assert property (
    (cell_enable && function_mode == lcs_pkg::FN_DFF_SR && gate_lines[3:1] == 3'h1 && $rose(gate_lines[0]))
    ##1 ($stable(gate_lines) && $stable(function_mode) && $stable(output_polarity) && cell_enable) [*3]
    |-> cell_output != output_polarity) else $error("flip-flop missed data");
endmodule

// *** lcs_input_mux.sv ***
/*
 * One input multiplexer of the logic cell: picks one signal of the pool
 * by a six-bit select code.
 * Assumes the pool is assembled by the caller; purely combinational.
 */
`timescale 1ns/100ps
module lcs_input_mux (
  // pool and select
  input wire logic [lcs_pkg::SRC_N-1:0] pool,
  input wire logic [lcs_pkg::SEL_W-1:0] select,
  // chosen signal
  output logic chosen
);

  // no clocking: a pin or foreign clock reaches the gates at once
  always_comb begin
    if (select <= lcs_pkg::CODE_MAX) begin
      chosen = pool[select];
    end else begin
      chosen = 1'b0;
    end
  end

endmodule

// *** lcs_logic_cell.sv ***
/*
 * Configurable logic cell: four input multiplexers, four gated logic
 * lines, one of eight logic functions and output polarity.
 * Assumes configuration ports are driven by software-written registers
 * on the same clock; source inputs may be asynchronous.
 */

`timescale 1ns/100ps
module lcs_logic_cell (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration
  input wire logic cell_enable,
  input wire logic [lcs_pkg::SEL_W-1:0] mux1_select,
  input wire logic [lcs_pkg::SEL_W-1:0] mux2_select,
  input wire logic [lcs_pkg::SEL_W-1:0] mux3_select,
  input wire logic [lcs_pkg::SEL_W-1:0] mux4_select,
  input wire logic [lcs_pkg::GSEL_W-1:0] gate1_select,
  input wire logic [lcs_pkg::GSEL_W-1:0] gate2_select,
  input wire logic [lcs_pkg::GSEL_W-1:0] gate3_select,
  input wire logic [lcs_pkg::GSEL_W-1:0] gate4_select,
  input wire logic [lcs_pkg::LINES-1:0] gate_polarity,
  input wire logic [2:0] function_mode,
  input wire logic output_polarity,
  input wire logic pin_output_enable,
  // general pool codes 0 to 31: pins, other cells, peripherals, register bits
  input wire logic [lcs_pkg::GEN_N-1:0] general_source,
  // pulse width modulators
  input wire logic pulse_mod5_output,
  input wire logic pulse_mod6_output,
  input wire logic pulse_mod11_output,
  // serial ports and zero cross
  input wire logic sync_serial_port_clock,
  input wire logic sync_serial_port_data,
  input wire logic zero_cross_output,
  input wire logic async_serial_port_tx,
  input wire logic async_serial_port_rx,
  // timers
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timer3_overflow,
  input wire logic timer5_overflow,
  input wire logic timer2_postscaled,
  input wire logic timer4_postscaled,
  input wire logic timer6_postscaled,
  input wire logic timer8_postscaled,
  // flags, clocks, modulator
  input wire logic pin_change_flag,
  input wire logic converter_rc_clock,
  input wire logic slow_internal_osc,
  input wire logic fast_internal_osc,
  input wire logic system_osc_clock,
  input wire logic modulator1_output,
  // results
  output logic cell_output,
  output logic cell_pin_out,
  output logic cell_pin_oe,
  output logic [lcs_pkg::LINES-1:0] gate_lines
);

  logic [lcs_pkg::SRC_N-1:0] pool;
  logic [lcs_pkg::LINES-1:0] data_sel;
  logic [lcs_pkg::SEL_W-1:0] mux_select_field [lcs_pkg::LINES];
  logic [lcs_pkg::GSEL_W-1:0] gate_sel [lcs_pkg::LINES];
  logic [lcs_pkg::GSEL_W-1:0] gate_terms;
  logic [lcs_pkg::LINES-1:0] line;

  // synchroniser and edge memory
  logic [lcs_pkg::LINES-1:0] sync1_q;
  logic [lcs_pkg::LINES-1:0] sync1_d;
  logic [lcs_pkg::LINES-1:0] sync2_q;
  logic [lcs_pkg::LINES-1:0] sync2_d;
  logic line1_prev_q;
  logic line1_prev_d;

  // stored state and function results
  logic state_q;
  logic state_d;
  logic clk_rise;
  logic comb_result;
  logic func_result;
  lcs_pkg::lcs_func_t mode;

  // input pool; the reserved code and code gaps stay low
  always_comb begin
    pool = '0;
    pool[lcs_pkg::GEN_N-1:0] = general_source;
    pool[lcs_pkg::CODE_PWM5] = pulse_mod5_output;
    pool[lcs_pkg::CODE_PWM6] = pulse_mod6_output;
    pool[lcs_pkg::CODE_PWM11] = pulse_mod11_output;
    pool[lcs_pkg::CODE_SSP_CLOCK] = sync_serial_port_clock;
    pool[lcs_pkg::CODE_SSP_DATA] = sync_serial_port_data;
    pool[lcs_pkg::CODE_ZERO_CROSS] = zero_cross_output;
    pool[lcs_pkg::CODE_UART_TX] = async_serial_port_tx;
    pool[lcs_pkg::CODE_UART_RX] = async_serial_port_rx;
    pool[lcs_pkg::CODE_TMR0_OVF] = timer0_overflow;
    pool[lcs_pkg::CODE_TMR1_OVF] = timer1_overflow;
    pool[lcs_pkg::CODE_TMR3_OVF] = timer3_overflow;
    pool[lcs_pkg::CODE_TMR5_OVF] = timer5_overflow;
    pool[lcs_pkg::CODE_TMR2_POST] = timer2_postscaled;
    pool[lcs_pkg::CODE_TMR4_POST] = timer4_postscaled;
    pool[lcs_pkg::CODE_TMR6_POST] = timer6_postscaled;
    pool[lcs_pkg::CODE_TMR8_POST] = timer8_postscaled;
    pool[lcs_pkg::CODE_PIN_CHANGE] = pin_change_flag;
    pool[lcs_pkg::CODE_CONV_RC] = converter_rc_clock;
    pool[lcs_pkg::CODE_SLOW_OSC] = slow_internal_osc;
    pool[lcs_pkg::CODE_FAST_OSC] = fast_internal_osc;
    pool[lcs_pkg::CODE_SYS_OSC] = system_osc_clock;
    pool[lcs_pkg::CODE_MODULATOR] = modulator1_output;
    pool[lcs_pkg::CODE_RESERVED] = 1'b0;
  end

  // select fields are not reset here; software must write them first
  assign mux_select_field[0] = mux1_select;
  assign mux_select_field[1] = mux2_select;
  assign mux_select_field[2] = mux3_select;
  assign mux_select_field[3] = mux4_select;

  assign gate_sel[0] = gate1_select;
  assign gate_sel[1] = gate2_select;
  assign gate_sel[2] = gate3_select;
  assign gate_sel[3] = gate4_select;

  // selected data, true and inverted, bit 2k true, bit 2k+1 inverted
  assign gate_terms = {~data_sel[3], data_sel[3], ~data_sel[2], data_sel[2],
                       ~data_sel[1], data_sel[1], ~data_sel[0], data_sel[0]};

  // stage one and two: data selection then gating
  genvar k;
  generate
    for (k = 0; k < lcs_pkg::LINES; k = k + 1) begin : g_lane
      // each lane has its own mux; codes past the pool read low
      lcs_input_mux u_mux (
        .pool(pool),
        .select(mux_select_field[k]),
        .chosen(data_sel[k])
      );
      // an empty gate select gives low, or high when inverted
      assign line[k] = gate_polarity[k] ^ (|(gate_sel[k] & gate_terms));
    end
  endgenerate

  assign gate_lines = line;
  assign mode = lcs_pkg::lcs_func_t'(function_mode);

  // stage three, combinational functions: no clock in the path
  always_comb begin
    case (mode)
      lcs_pkg::FN_AND_OR: begin
        comb_result = (line[0] & line[1]) | (line[2] & line[3]);
      end
      lcs_pkg::FN_OR_XOR: begin
        comb_result = (line[0] | line[1]) ^ (line[2] | line[3]);
      end
      lcs_pkg::FN_AND4: begin
        comb_result = &line;
      end
      default: begin
        // storage modes take their result from state_q
        comb_result = 1'b0;
      end
    endcase
  end

  // storage functions look at synchronised lines, so a pin-driven
  // clock line is seen two to three system clocks late
  always_comb begin
    sync1_d = line;
    sync2_d = sync1_q;
    line1_prev_d = sync2_q[0];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      line1_prev_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      line1_prev_q <= line1_prev_d;
    end
  end

  // a line 1 pulse shorter than one clock can be missed
  assign clk_rise = sync2_q[0] & ~line1_prev_q;

  // line 1 clock, line 2 data, line 3 reset, line 4 set in FN_DFF_SR
  // reset beats set in every storage mode
  always_comb begin
    state_d = state_q;
    case (mode)
      lcs_pkg::FN_SR_LATCH: begin
        // set from lines 1,2; reset from lines 3,4; reset dominates
        if (sync2_q[2] | sync2_q[3]) begin
          state_d = 1'b0;
        end else if (sync2_q[0] | sync2_q[1]) begin
          state_d = 1'b1;
        end
      end
      lcs_pkg::FN_DFF_SR: begin
        // line 1 rise loads line 2
        if (sync2_q[2]) begin
          state_d = 1'b0;
        end else if (sync2_q[3]) begin
          state_d = 1'b1;
        end else if (clk_rise) begin
          state_d = sync2_q[1];
        end
      end
      lcs_pkg::FN_DFF2_R: begin
        // data is line 2 or line 4
        if (sync2_q[2]) begin
          state_d = 1'b0;
        end else if (clk_rise) begin
          state_d = sync2_q[1] | sync2_q[3];
        end
      end
      lcs_pkg::FN_JK_R: begin
        // line 2 is J, line 4 is K
        if (sync2_q[2]) begin
          state_d = 1'b0;
        end else if (clk_rise) begin
          case ({sync2_q[1], sync2_q[3]})
            2'b10: begin
              state_d = 1'b1;
            end
            2'b01: begin
              state_d = 1'b0;
            end
            2'b11: begin
              // both high toggles
              state_d = ~state_q;
            end
            default: begin
              state_d = state_q;
            end
          endcase
        end
      end
      lcs_pkg::FN_DLATCH_SR: begin
        // line 1 is latch enable while high
        if (sync2_q[2]) begin
          state_d = 1'b0;
        end else if (sync2_q[3]) begin
          state_d = 1'b1;
        end else if (sync2_q[0]) begin
          state_d = sync2_q[1];
        end
      end
      default: begin
        // combinational mode: clear so a later switch starts clean
        state_d = lcs_pkg::STATE_RESET;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= lcs_pkg::STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // stage four: polarity; configuration acts the moment it changes
  always_comb begin
    case (mode)
      lcs_pkg::FN_AND_OR, lcs_pkg::FN_OR_XOR, lcs_pkg::FN_AND4: begin
        func_result = comb_result;
      end
      default: begin
        func_result = state_q;
      end
    endcase
  end

  // NAND, AND-OR-INVERT and OR-XNOR come from the inverted polarity
  assign cell_output = cell_enable & (func_result ^ output_polarity);
  // the pin copy follows the cell output; oe also needs the enable
  assign cell_pin_out = cell_output;
  assign cell_pin_oe = cell_enable & pin_output_enable;

endmodule

// *** lcs_pkg.sv ***
/*
 * Shared constants for the configurable logic cell: select codes of the
 * input pool, field widths and logic function encodings.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lcs_pkg;

  // widths
  localparam int SEL_W = 6;
  localparam int SRC_N = 55;
  localparam int GEN_N = 32;
  localparam int LINES = 4;
  localparam int GSEL_W = 8;

  // highest code that names a source; codes above feed logic low
  localparam logic [5:0] CODE_MAX = 6'h0036;

  // input pool select codes
  localparam logic [5:0] CODE_MODULATOR = 6'h0036;
  localparam logic [5:0] CODE_SYS_OSC = 6'h0035;
  localparam logic [5:0] CODE_FAST_OSC = 6'h0034;
  localparam logic [5:0] CODE_SLOW_OSC = 6'h0033;
  localparam logic [5:0] CODE_CONV_RC = 6'h0032;
  localparam logic [5:0] CODE_PIN_CHANGE = 6'h0031;
  localparam logic [5:0] CODE_TMR8_POST = 6'h0030;
  localparam logic [5:0] CODE_TMR6_POST = 6'h002f;
  localparam logic [5:0] CODE_TMR4_POST = 6'h002e;
  localparam logic [5:0] CODE_TMR2_POST = 6'h002d;
  localparam logic [5:0] CODE_TMR5_OVF = 6'h002c;
  localparam logic [5:0] CODE_TMR3_OVF = 6'h002b;
  localparam logic [5:0] CODE_TMR1_OVF = 6'h002a;
  localparam logic [5:0] CODE_TMR0_OVF = 6'h0029;
  localparam logic [5:0] CODE_UART_RX = 6'h0028;
  localparam logic [5:0] CODE_UART_TX = 6'h0027;
  localparam logic [5:0] CODE_ZERO_CROSS = 6'h0026;
  localparam logic [5:0] CODE_SSP_DATA = 6'h0025;
  localparam logic [5:0] CODE_SSP_CLOCK = 6'h0024;
  localparam logic [5:0] CODE_RESERVED = 6'h0023;
  localparam logic [5:0] CODE_PWM11 = 6'h0022;
  localparam logic [5:0] CODE_PWM6 = 6'h0021;
  localparam logic [5:0] CODE_PWM5 = 6'h0020;

  // logic function encodings
  typedef enum logic [2:0] {
    FN_AND_OR = 3'b000,
    FN_OR_XOR = 3'b001,
    FN_AND4 = 3'b010,
    FN_SR_LATCH = 3'b011,
    FN_DFF_SR = 3'b100,
    FN_DFF2_R = 3'b101,
    FN_JK_R = 3'b110,
    FN_DLATCH_SR = 3'b111
  } lcs_func_t;

  // reset value of the stored state of the latch functions
  localparam logic STATE_RESET = 1'b0;

endpackage

// *** lcs_source_model.sv ***
/*
 * Source model for the cell's input pool: pins, clocks, peripherals
 * and register bits, one bit per select code.
 * Assumes the bench sets the levels it wants on the pool.
 */
`timescale 1ns/100ps
module lcs_source_model (
  // requested levels
  input wire logic [63:0] level,
  // pool, bit n answers select code n
  output logic [lcs_pkg::SRC_N-1:0] pool
);
  // all source kinds come from one word so every code can be driven
  assign pool = level[lcs_pkg::SRC_N-1:0];
endmodule

// *** testbench.sv ***
/*
 * Bench for the logic cell: every select code on every mux, function
 * table, storage latency, reset and enable.
 * Assumes lcs_pkg, the cell, the source model and the checker.
 */
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [2:0] mode;
    logic opol;
    logic [3:0] lines;
    logic res;
  } lcs_row_t;
  logic clock, rst_n, cell_enable, output_polarity, pin_output_enable;
  logic [5:0] sel [4];
  logic [7:0] gsel [4];
  logic [3:0] gate_polarity;
  logic [2:0] function_mode;
  logic [63:0] level;
  logic [lcs_pkg::SRC_N-1:0] pool;
  logic cell_output, cell_pin_out, cell_pin_oe;
  logic [3:0] gate_lines;
  int err_count, check_count, cycles;
  lcs_row_t rows [11] = '{'{3'h2, 1'h0, 4'hf, 1'h1}, '{3'h2, 1'h0, 4'h7, 1'h0}, '{3'h2, 1'h1, 4'he, 1'h1},
    '{3'h0, 1'h0, 4'h3, 1'h1}, '{3'h0, 1'h0, 4'hc, 1'h1}, '{3'h0, 1'h0, 4'h5, 1'h0}, '{3'h0, 1'h1, 4'h3, 1'h0},
    '{3'h1, 1'h0, 4'h1, 1'h1}, '{3'h1, 1'h0, 4'h5, 1'h0}, '{3'h1, 1'h1, 4'h4, 1'h0}, '{3'h1, 1'h1, 4'h0, 1'h1}};

  lcs_source_model src (.level(level), .pool(pool));
  lcs_logic_cell uut (.clock, .rst_n, .cell_enable,
    .mux1_select(sel[0]), .mux2_select(sel[1]), .mux3_select(sel[2]), .mux4_select(sel[3]),
    .gate1_select(gsel[0]), .gate2_select(gsel[1]), .gate3_select(gsel[2]), .gate4_select(gsel[3]),
    .gate_polarity, .function_mode, .output_polarity, .pin_output_enable,
    .general_source(pool[31:0]), .pulse_mod5_output(pool[32]), .pulse_mod6_output(pool[33]),
    .pulse_mod11_output(pool[34]), .sync_serial_port_clock(pool[36]), .sync_serial_port_data(pool[37]),
    .zero_cross_output(pool[38]), .async_serial_port_tx(pool[39]), .async_serial_port_rx(pool[40]),
    .timer0_overflow(pool[41]), .timer1_overflow(pool[42]), .timer3_overflow(pool[43]),
    .timer5_overflow(pool[44]), .timer2_postscaled(pool[45]), .timer4_postscaled(pool[46]),
    .timer6_postscaled(pool[47]), .timer8_postscaled(pool[48]), .pin_change_flag(pool[49]),
    .converter_rc_clock(pool[50]), .slow_internal_osc(pool[51]), .fast_internal_osc(pool[52]),
    .system_osc_clock(pool[53]), .modulator1_output(pool[54]),
    .cell_output, .cell_pin_out, .cell_pin_oe, .gate_lines);

  task automatic compare(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // reserved and unlisted codes read low
  function automatic logic src_bit(input logic [63:0] w, input logic [5:0] c);
    if (c > lcs_pkg::CODE_MAX || c == lcs_pkg::CODE_RESERVED) return 1'b0;
    return w[c];
  endfunction

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    logic [3:0] exp;
    logic [63:0] w;
    rst_n = 1'b0;
    cell_enable = 1'b1;
    output_polarity = 1'b0;
    pin_output_enable = 1'b1;
    gate_polarity = 4'h0;
    function_mode = lcs_pkg::FN_AND4;
    level = 64'h0;
    for (int k = 0; k < 4; k++) begin
      sel[k] = 6'h00;
      gsel[k] = 8'h01 << (2 * k);
    end
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    // muxes sit 16 codes apart so all four steer independently; checked with no clock edge between
    for (int p = 0; p < 2; p++) begin
      w = p ? 64'ha5c3_96f0_3c5a_0f69 : ~64'ha5c3_96f0_3c5a_0f69;
      for (int c = 0; c < 64; c++) begin
        @(negedge clock);
        level = w;
        for (int k = 0; k < 4; k++) begin
          sel[k] = 6'(c + 16 * k);
          exp[k] = src_bit(w, 6'(c + 16 * k));
        end
        #1;
        compare(gate_lines, exp);
        compare({3'h0, cell_output}, {3'h0, &exp});
      end
    end
    @(negedge clock);
    foreach (gsel[k]) gsel[k] = 8'h00;
    foreach (rows[i]) begin
      @(negedge clock);
      function_mode = rows[i].mode;
      output_polarity = rows[i].opol;
      gate_polarity = rows[i].lines;
      #1;
      compare({3'h0, cell_output}, {3'h0, rows[i].res});
    end
    @(negedge clock);
    function_mode = lcs_pkg::FN_DFF_SR;
    output_polarity = 1'b0;
    gate_polarity = 4'h2;
    repeat (3) @(negedge clock);
    gate_polarity = 4'h3;
    repeat (2) @(negedge clock);
    compare({3'h0, cell_output}, 4'h0);
    @(negedge clock);
    compare({3'h0, cell_output}, 4'h1);
    @(negedge clock);
    gate_polarity = 4'h4;
    repeat (4) @(negedge clock);
    compare({3'h0, cell_output}, 4'h0);
    function_mode = lcs_pkg::FN_SR_LATCH;
    gate_polarity = 4'h1;
    repeat (4) @(negedge clock);
    compare({3'h0, cell_output}, 4'h1);
    gate_polarity = 4'h0;
    repeat (4) @(negedge clock);
    compare({3'h0, cell_output}, 4'h1);
    gate_polarity = 4'h5;
    repeat (4) @(negedge clock);
    compare({3'h0, cell_output}, 4'h0);
    // jk: line 1 clock, line 2 j, line 4 k; set, then toggle back
    function_mode = lcs_pkg::FN_JK_R;
    gate_polarity = 4'h2;
    repeat (3) @(negedge clock);
    gate_polarity = 4'h3;
    repeat (4) @(negedge clock);
    compare({3'h0, cell_output}, 4'h1);
    gate_polarity = 4'ha;
    repeat (3) @(negedge clock);
    gate_polarity = 4'hb;
    repeat (4) @(negedge clock);
    compare({3'h0, cell_output}, 4'h0);
    // two-input flip-flop takes line 4 as data too
    function_mode = lcs_pkg::FN_DFF2_R;
    gate_polarity = 4'h8;
    repeat (3) @(negedge clock);
    gate_polarity = 4'h9;
    repeat (4) @(negedge clock);
    compare({3'h0, cell_output}, 4'h1);
    // transparent latch: follows line 2 while line 1 high, then holds
    function_mode = lcs_pkg::FN_DLATCH_SR;
    gate_polarity = 4'h1;
    repeat (4) @(negedge clock);
    compare({3'h0, cell_output}, 4'h0);
    gate_polarity = 4'h3;
    repeat (4) @(negedge clock);
    compare({3'h0, cell_output}, 4'h1);
    gate_polarity = 4'h0;
    repeat (4) @(negedge clock);
    compare({3'h0, cell_output}, 4'h1);
    // stored state is zero in reset, so only polarity shows
    output_polarity = 1'b1;
    rst_n = 1'b0;
    #1;
    compare({3'h0, cell_output}, 4'h1);
    @(negedge clock);
    rst_n = 1'b1;
    function_mode = lcs_pkg::FN_AND4;
    output_polarity = 1'b0;
    gate_polarity = 4'hf;
    cell_enable = 1'b0;
    #1;
    compare({1'h0, cell_output, cell_pin_out, cell_pin_oe}, 4'h0);
    @(negedge clock);
    cell_enable = 1'b1;
    #1;
    compare({1'h0, cell_output, cell_pin_out, cell_pin_oe}, 4'h7);
    @(negedge clock);
    pin_output_enable = 1'b0;
    #1;
    compare({1'h0, cell_output, cell_pin_out, cell_pin_oe}, 4'h6);
    summarize();
  end
endmodule

bind lcs_logic_cell lcs_cell_asserts u_chk (.clock, .rst_n, .cell_enable, .gate1_select, .gate2_select,
  .gate3_select, .gate4_select, .gate_polarity, .function_mode, .output_polarity, .pin_output_enable,
  .cell_output, .cell_pin_out, .cell_pin_oe, .gate_lines);
